// ===== design/rudc_pkg.sv
// rudc_pkg: constants for the reset and usb detach controller.
// assumes a 100 MHz core clock and a 32-bit avalon-mm register bus.
//
// How it works
// - setting detach enable stops the usb pll; usb attach stays asserted
// - while detached the power state output shows low power state one
// - link return or enabled wake gpio restarts the pll and runs a usb reset without host action
// - detach return flag is readable so a driver sees why it re-enumerated
// - power-on holds chip reset for about 22 ms by an internal timer
// - power-on reset requests an eeprom configuration load
// - after por, pin, soft, usb reset or unpowered exit the phy is powered down
// - pin reset low resets chip; ready reads 0 until reset completes
// - external reset pin is ignored while unpowered
// - lite reset spares usb controller and phy, keeps pll, no usb reload
// - writing 1 to config bit 0 starts soft reset; bit self-clears after 2 us
// - soft reset keeps bits marked kept-through-soft-reset, clears the rest
// - soft reset reloads eeprom configuration
// - soft reset disconnects usb after first good out data packet, after ack in hs
// - usb reset spares usb core, pll on; por, pin, soft resets force disconnect then it
// - after usb reset ready is 0 until eeprom loaded; only mac address reloaded
// - usb power loss enters unpowered state in reset; return reloads eeprom
// - straps float during por or pin reset, latched at release, outputs after
// - test port controller uses its own active-low reset input
package rudc_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] RUDC_HARDWARE_CONFIG_REGISTER_ADDR  = 8'h00;
  localparam logic [7:0] RUDC_PMT_CTL_ADDR = 8'h04;
  localparam logic [7:0] RUDC_STATUS_ADDR  = 8'h08;

  // hardware_config_register fields
  localparam int RUDC_SOFT_RESET_BIT_BIT   = 0;
  localparam int RUDC_LITE_RESET_BIT_BIT   = 1;
  localparam int RUDC_DET_EN_BIT = 2;
  localparam int RUDC_DET_ST_BIT = 3;
  localparam int RUDC_GPIO_LO    = 8;
  localparam int RUDC_GPIO_W     = 4;
  // bits kept through soft reset: gpio select and detach flag
  localparam logic [31:0] RUDC_KEEP_MASK = 32'h0000_0f08;

  // power_mgmt_control_register fields
  localparam int RUDC_READY_BIT  = 0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int RUDC_CLK_MHZ     = 100;
  localparam int RUDC_POR_US      = 22000;
  localparam int RUDC_POR_CYC     = RUDC_POR_US * RUDC_CLK_MHZ;
  localparam int RUDC_SOFT_RESET_BIT_NS     = 2000;
  localparam int RUDC_SOFT_RESET_BIT_CYC    = (RUDC_SOFT_RESET_BIT_NS * RUDC_CLK_MHZ + 999) / 1000;
  localparam int RUDC_DISC_CYC    = 16;
  localparam int RUDC_USBRST_CYC  = 16;

  // sequencer states
  typedef enum logic [5:0] {
    RUDC_S_POR    = 6'b000001,
    RUDC_S_UNPWR  = 6'b000010,
    RUDC_S_DISC   = 6'b000100,
    RUDC_S_USBRST = 6'b001000,
    RUDC_S_LOAD   = 6'b010000,
    RUDC_S_RUN    = 6'b100000
  } rudc_state_t;

endpackage : rudc_pkg

// ===== design/rudc_top.sv
// rudc_top: reset sequencer, cable-detach control and strap latch.
// assumes all inputs synchronous to sys_clk; rst models power-on.
//
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module rudc_top #(
  parameter int POR_CYC   = rudc_pkg::RUDC_POR_CYC,
  parameter int GPIO_W    = rudc_pkg::RUDC_GPIO_W,
  parameter int STRAP_W   = 4
) (
  // clock and power-on reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // avalon-mm slave
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // reset sources
  input  wire logic                 external_reset_n,
  input  wire logic                 usb_power_detect,
  input  wire logic                 usb_bus_reset,
  input  wire logic                 test_port_reset_n,
  // usb side
  input  wire logic                 usb_good_out_data,
  input  wire logic                 usb_ack_sent,
  input  wire logic                 usb_high_speed,
  output logic                      usb_attach,
  output logic                      usb_pll_enable,
  // detach wake sources
  input  wire logic                 eth_link_up,
  input  wire logic [GPIO_W-1:0]    gpio_in,
  // eeprom loader
  output logic                      eeprom_load_full,
  output logic                      eeprom_load_mac,
  input  wire logic                 eeprom_done,
  // reset and power outputs
  output logic                      chip_reset,
  output logic                      core_reset,
  output logic                      usb_core_reset,
  output logic                      phy_power_down,
  output logic                      low_power_state_one,
  output logic                      test_port_reset,
  // configuration straps
  input  wire logic [STRAP_W-1:0]   strap_in,
  output logic      [STRAP_W-1:0]   strap_oe,
  output logic      [STRAP_W-1:0]   strap_value
);

  // gpio select owns a 4-bit field of the config word
  if (POR_CYC < 1 || GPIO_W < 1 || GPIO_W > 4 || STRAP_W < 1) begin : g_param_check
    $error("rudc_top: unsupported parameters");
  end

  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  rudc_pkg::rudc_state_t state_r, state_nxt;
  logic [31:0] por_cnt_r, por_cnt_nxt;
  logic [7:0]  soft_reset_bit_cnt_r;
  logic [7:0]  step_cnt_r;
  logic        soft_reset_bit_r, lite_reset_bit_r, det_en_r, det_sts_r;
  logic [GPIO_W-1:0] gpio_sel_r;
  logic        soft_reset_bit_armed_r;
  logic        full_load_r;
  logic        ready_r;
  logic        detached_r;
  logic [STRAP_W-1:0] strap_r;
  logic        strap_hold_r;
  logic [31:0] rdata_r;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  wire sel_cfg   = avs_address == rudc_pkg::RUDC_HARDWARE_CONFIG_REGISTER_ADDR;
  wire sel_pmt   = avs_address == rudc_pkg::RUDC_PMT_CTL_ADDR;
  wire sel_sts   = avs_address == rudc_pkg::RUDC_STATUS_ADDR;
  // writes land only at the edge where waitrequest is low
  wire wr_cfg    = avs_write && !avs_waitrequest && sel_cfg && !core_reset;
  wire be0       = avs_byteenable[0];
  wire be1       = avs_byteenable[1];
  wire wr_soft_reset_bit   = wr_cfg && be0 && avs_writedata[rudc_pkg::RUDC_SOFT_RESET_BIT_BIT];
  wire wr_lite_reset_bit   = wr_cfg && be0 && avs_writedata[rudc_pkg::RUDC_LITE_RESET_BIT_BIT];
  wire wr_det    = wr_cfg && be0 && avs_writedata[rudc_pkg::RUDC_DET_EN_BIT];

  // one wait cycle per access: registered read data
  logic ack_r;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  wire [31:0] cfg_word = {20'h0, 4'(gpio_sel_r), 4'h0, det_sts_r, det_en_r, lite_reset_bit_r, soft_reset_bit_r};
  wire [31:0] sts_word = {26'h0, state_r};
  wire [31:0] rd_mux   = sel_cfg ? cfg_word :
                         sel_pmt ? {31'h0, ready_r} :
                         sel_sts ? sts_word : 32'h0;

  // ------------------------------------------------------------
  // reset source merge
  // ------------------------------------------------------------
  wire pin_rst     = !external_reset_n && usb_power_detect;
  wire unpowered   = !usb_power_detect;
  wire soft_reset_bit_done   = soft_reset_bit_r && (soft_reset_bit_cnt_r == 8'(rudc_pkg::RUDC_SOFT_RESET_BIT_CYC - 1));
  wire soft_reset_bit_disc   = soft_reset_bit_armed_r &&
                     (usb_high_speed ? usb_ack_sent : usb_good_out_data);
  wire wake_detach = detached_r &&
                     (eth_link_up || |(gpio_in & gpio_sel_r));

  wire in_por    = state_r == rudc_pkg::RUDC_S_POR;
  wire in_unpwr  = state_r == rudc_pkg::RUDC_S_UNPWR;
  wire in_disc   = state_r == rudc_pkg::RUDC_S_DISC;
  wire in_usbrst = state_r == rudc_pkg::RUDC_S_USBRST;
  wire in_load   = state_r == rudc_pkg::RUDC_S_LOAD;
  wire in_run    = state_r == rudc_pkg::RUDC_S_RUN;
  wire step_end  = step_cnt_r == (in_usbrst ? 8'(rudc_pkg::RUDC_USBRST_CYC - 1) :
                                              8'(rudc_pkg::RUDC_DISC_CYC - 1));

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    por_cnt_nxt = por_cnt_r;
    unique case (state_r)
      rudc_pkg::RUDC_S_POR: begin
        por_cnt_nxt = por_cnt_r + 32'h1;
        if (por_cnt_r == 32'(POR_CYC - 1)) begin
          state_nxt = rudc_pkg::RUDC_S_DISC;
        end
      end
      rudc_pkg::RUDC_S_UNPWR: begin
        if (usb_power_detect) begin
          state_nxt = rudc_pkg::RUDC_S_DISC;
        end
      end
      rudc_pkg::RUDC_S_DISC: begin
        if (step_end && !pin_rst) begin
          state_nxt = rudc_pkg::RUDC_S_USBRST;
        end
      end
      rudc_pkg::RUDC_S_USBRST: begin
        if (step_end) begin
          state_nxt = rudc_pkg::RUDC_S_LOAD;
        end
      end
      rudc_pkg::RUDC_S_LOAD: begin
        if (eeprom_done) begin
          state_nxt = rudc_pkg::RUDC_S_RUN;
        end
      end
      rudc_pkg::RUDC_S_RUN: begin
        if (usb_bus_reset || wake_detach) begin
          state_nxt = rudc_pkg::RUDC_S_USBRST;
        end
      end
    endcase
    if (unpowered && !in_por) begin
      state_nxt = rudc_pkg::RUDC_S_UNPWR;
    end else if ((pin_rst || soft_reset_bit_disc) && !in_por && !in_unpwr) begin
      state_nxt = rudc_pkg::RUDC_S_DISC;
    end
  end

  // a pin or soft reset loads everything; usb reset only the mac address
  wire enter_disc = state_nxt == rudc_pkg::RUDC_S_DISC && !in_disc;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r     <= rudc_pkg::RUDC_S_POR;
      por_cnt_r   <= 32'h0;
      step_cnt_r  <= 8'h0;
      full_load_r <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      por_cnt_r   <= por_cnt_nxt;
      // a held pin reset restarts the disconnect count so it cannot wrap
      step_cnt_r  <= (state_nxt != state_r || pin_rst) ? 8'h0 : step_cnt_r + 8'h1;
      if (enter_disc) begin
        full_load_r <= 1'b1;
      end else if (in_load && eeprom_done) begin
        full_load_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // hardware config: soft, lite reset and detach
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      soft_reset_bit_r       <= 1'b0;
      soft_reset_bit_cnt_r   <= 8'h0;
      soft_reset_bit_armed_r <= 1'b0;
      lite_reset_bit_r       <= 1'b0;
      det_en_r     <= 1'b0;
      det_sts_r    <= 1'b0;
      gpio_sel_r   <= '0;
      detached_r   <= 1'b0;
    end else begin
      if (wr_soft_reset_bit) begin
        soft_reset_bit_r       <= 1'b1;
        soft_reset_bit_armed_r <= 1'b1;
        soft_reset_bit_cnt_r   <= 8'h0;
      end else if (soft_reset_bit_done) begin
        soft_reset_bit_r       <= 1'b0;
      end else if (soft_reset_bit_r) begin
        soft_reset_bit_cnt_r   <= soft_reset_bit_cnt_r + 8'h1;
      end
      if (soft_reset_bit_disc) begin
        soft_reset_bit_armed_r <= 1'b0;
      end
      lite_reset_bit_r <= wr_lite_reset_bit;
      if (wr_cfg && be1) begin
        gpio_sel_r <= avs_writedata[rudc_pkg::RUDC_GPIO_LO +: GPIO_W];
      end
      if (wr_det) begin
        det_en_r   <= 1'b1;
        detached_r <= 1'b1;
      end else if (wake_detach) begin
        det_en_r   <= 1'b0;
        detached_r <= 1'b0;
      end
      // set wins over a software clear of the flag
      if (wake_detach) begin
        det_sts_r <= 1'b1;
      end else if (wr_cfg && be0 && avs_writedata[rudc_pkg::RUDC_DET_ST_BIT]) begin
        det_sts_r <= 1'b0;
      end
      if (soft_reset_bit_done) begin
        det_en_r <= 1'b0;
      end
      if (pin_rst || unpowered) begin
        det_en_r   <= 1'b0;
        detached_r <= 1'b0;
        det_sts_r  <= 1'b0;
        gpio_sel_r <= '0;
        soft_reset_bit_r     <= 1'b0;
        soft_reset_bit_armed_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // ready, straps, bus readback
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ready_r      <= 1'b0;
      strap_hold_r <= 1'b1;
      strap_r      <= '0;
      ack_r        <= 1'b0;
      rdata_r      <= 32'h0;
    end else begin
      ready_r     <= in_run && !soft_reset_bit_r;
      if (strap_hold_r && !in_por && !pin_rst) begin
        strap_r      <= strap_in;
        strap_hold_r <= 1'b0;
      end else if (pin_rst) begin
        strap_hold_r <= 1'b1;
      end
      ack_r   <= (avs_read || avs_write) && !ack_r;
      rdata_r <= rd_mux;
    end
  end

  assign avs_readdata = rdata_r;

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign chip_reset          = in_por || in_unpwr || pin_rst;
  assign core_reset          = chip_reset || in_disc || in_usbrst || lite_reset_bit_r;
  assign usb_core_reset      = chip_reset;
  assign usb_attach          = in_run || in_load || in_usbrst;
  assign usb_pll_enable      = !detached_r && !in_unpwr;
  assign low_power_state_one = detached_r;
  assign phy_power_down      = !in_run || chip_reset;
  assign eeprom_load_full    = in_load && full_load_r;
  assign eeprom_load_mac     = in_load && !full_load_r;
  assign test_port_reset     = !test_port_reset_n;
  assign strap_oe            = strap_hold_r ? '0 : '1;
  assign strap_value         = strap_r;

endmodule : rudc_top

// ===== sim/rudc_host_model.sv
// rudc_host_model: usb host traffic and eeprom loader answers.
// assumes the bench pulses send_out for one cycle per out data stage.
`timescale 1ns/100ps
module rudc_host_model (
  // clock and control
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic send_out,
  input  wire logic usb_high_speed,
  // loader side
  input  wire logic eeprom_load_full,
  input  wire logic eeprom_load_mac,
  output logic      eeprom_done,
  // usb events
  output logic      usb_good_out_data,
  output logic      usb_ack_sent
);
  logic [3:0] cnt_r;
  always_ff @(posedge sys_clk) begin
    eeprom_done       <= 1'b0;
    usb_good_out_data <= send_out;
    // ack only follows good data in high speed
    usb_ack_sent      <= usb_good_out_data && usb_high_speed;
    if (rst || !(eeprom_load_full || eeprom_load_mac)) begin
      cnt_r <= 4'h0;
    end else if (cnt_r == (slow ? 4'h9 : 4'h1)) begin
      eeprom_done <= 1'b1;
      cnt_r       <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : rudc_host_model

// ===== sim/rudc_top_sva.sv
// rudc_top_sva: port-level checks of the reset and detach sequencer.
// assumes it is bound into rudc_top; single sys_clk domain, rst sync high.
`timescale 1ns/100ps
module rudc_top_sva #(
  parameter int STRAP_W = 4
) (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               rst,
  // bus handshake
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic               avs_waitrequest,
  // reset sources
  input wire logic               external_reset_n,
  input wire logic               usb_power_detect,
  input wire logic               test_port_reset_n,
  // outputs watched
  input wire logic               test_port_reset,
  input wire logic               usb_pll_enable,
  input wire logic               usb_attach,
  input wire logic               low_power_state_one,
  input wire logic               eeprom_load_full,
  input wire logic               eeprom_load_mac,
  input wire logic               chip_reset,
  input wire logic               core_reset,
  input wire logic               phy_power_down,
  input wire logic [STRAP_W-1:0] strap_oe,
  input wire logic [STRAP_W-1:0] strap_value
);
  default clocking cb_clk @(posedge sys_clk); endclocking
  default disable iff (rst);

  tap_reset_a: assert property (test_port_reset == !test_port_reset_n)
    else $error("test port reset not the inverse of its pin");
  detach_pll_a: assert property (low_power_state_one |-> !usb_pll_enable)
    else $error("pll running while detached");
  unpwr_hold_a: assert property (!usb_power_detect [*2] |-> chip_reset && !usb_pll_enable)
    else $error("unpowered without chip reset");
  chip_core_a: assert property (chip_reset |-> core_reset)
    else $error("chip reset not merged into core reset");
  phy_down_a: assert property (chip_reset |-> phy_power_down)
    else $error("phy powered during chip reset");
  pin_reset_a: assert property ((usb_power_detect && !external_reset_n) [*2]
    |-> chip_reset && strap_oe == '0) else $error("pin reset without reset or floating straps");
  strap_hold_a: assert property ((strap_oe != '0) && $past(strap_oe != '0)
    |-> $stable(strap_value)) else $error("latched straps changed while driven");
  load_excl_a: assert property (eeprom_load_full |-> !eeprom_load_mac && usb_attach)
    else $error("full and mac load together or detached");
  wait_resp_a: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer not after one cycle");
endmodule : rudc_top_sva

bind rudc_top rudc_top_sva #(.STRAP_W(STRAP_W)) u_sva (
  .sys_clk(sys_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .external_reset_n(external_reset_n),
  .usb_power_detect(usb_power_detect), .test_port_reset_n(test_port_reset_n),
  .test_port_reset(test_port_reset), .usb_pll_enable(usb_pll_enable), .usb_attach(usb_attach),
  .low_power_state_one(low_power_state_one), .eeprom_load_full(eeprom_load_full),
  .eeprom_load_mac(eeprom_load_mac), .chip_reset(chip_reset), .core_reset(core_reset),
  .phy_power_down(phy_power_down), .strap_oe(strap_oe), .strap_value(strap_value));

// ===== sim/test_reset_and_usb_detach_control.sv
// test_reset_and_usb_detach_control: self-checking bench for rudc_top.
// assumes the host model answers loads; por count shortened to 50 cycles.
`timescale 1ns/100ps
module test_reset_and_usb_detach_control;
  localparam int POR = 50;
  logic sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0, external_reset_n = 1;
  logic usb_power_detect = 1, usb_bus_reset = 0, test_port_reset_n = 1, usb_high_speed = 0;
  logic eth_link_up = 0, slow = 0, send_out = 0, seen_full = 0, seen_mac = 0, seen_det = 0;
  logic [7:0] avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, q;
  logic [3:0] gpio_in = 0, strap_in = 0, strap_oe, strap_value, g, s;
  logic avs_waitrequest, usb_good_out_data, usb_ack_sent, usb_attach, usb_pll_enable;
  logic eeprom_load_full, eeprom_load_mac, eeprom_done, chip_reset, core_reset;
  logic usb_core_reset, phy_power_down, low_power_state_one, test_port_reset;
  int fail_count = 0, cmp_count = 0, cyc = 0, seed = 24, n;

  rudc_top #(.POR_CYC(POR), .GPIO_W(4), .STRAP_W(4)) dut (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .external_reset_n(external_reset_n),
    .usb_power_detect(usb_power_detect), .usb_bus_reset(usb_bus_reset),
    .test_port_reset_n(test_port_reset_n), .usb_good_out_data(usb_good_out_data),
    .usb_ack_sent(usb_ack_sent), .usb_high_speed(usb_high_speed), .usb_attach(usb_attach),
    .usb_pll_enable(usb_pll_enable), .eth_link_up(eth_link_up), .gpio_in(gpio_in),
    .eeprom_load_full(eeprom_load_full), .eeprom_load_mac(eeprom_load_mac),
    .eeprom_done(eeprom_done), .chip_reset(chip_reset), .core_reset(core_reset),
    .usb_core_reset(usb_core_reset), .phy_power_down(phy_power_down),
    .low_power_state_one(low_power_state_one), .test_port_reset(test_port_reset),
    .strap_in(strap_in), .strap_oe(strap_oe), .strap_value(strap_value));
  rudc_host_model u_host (.sys_clk(sys_clk), .rst(rst), .slow(slow), .send_out(send_out),
    .usb_high_speed(usb_high_speed), .eeprom_load_full(eeprom_load_full),
    .eeprom_load_mac(eeprom_load_mac), .eeprom_done(eeprom_done),
    .usb_good_out_data(usb_good_out_data), .usb_ack_sent(usb_ack_sent));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    test_port_reset_n <= 1'($random(seed));
    slow <= 1'($random(seed));
    if (eeprom_load_full === 1'b1) seen_full <= 1'b1;
    if (eeprom_load_mac === 1'b1) seen_mac <= 1'b1;
    if (usb_attach === 1'b0) seen_det <= 1'b1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  task automatic results;
    $display("counts: %0d mismatches in %0d compares", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: word %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cb(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : cb
  // one avalon access; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    q = avs_readdata;
    if (k == 50) fail_count++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : tick
  task automatic wait_ready;
    int k = 0;
    q = 0;
    while (q[0] !== 1'b1 && k < 300) begin
      bus(1'b0, 8'h04, 32'h0);
      k++;
    end
    if (k == 300) fail_count++;
  endtask : wait_ready
  // flags only cleared while the sequencer is idle
  task automatic clr;
    seen_full <= 1'b0;
    seen_mac <= 1'b0;
    seen_det <= 1'b0;
  endtask : clr

  initial begin
    tick(4);
    rst <= 1'b0;
    n = 0;
    tick(1);
    while (chip_reset === 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    cb(n >= POR - 2 && n <= POR + 2, 1'b1);
    wait_ready;
    cb(seen_full, 1'b1);
    // soft reset straight after power-up, as the driver must
    g = 4'($random(seed));
    clr;
    bus(1'b1, 8'h00, {20'h0, g, 8'h01});
    bus(1'b0, 8'h00, 32'h0);
    chk(q, {20'h0, g, 8'h01});
    cb(usb_attach, 1'b1);
    usb_high_speed <= 1'($random(seed));
    send_out <= 1'b1;
    tick(1);
    send_out <= 1'b0;
    tick(220);
    wait_ready;
    bus(1'b0, 8'h00, 32'h0);
    chk(q, {20'h0, g, 8'h00});
    cb(seen_full, 1'b1);
    cb(seen_det, 1'b1);
    // detach, then wake by link (k=0) or by a selected gpio (k=1)
    for (int k = 0; k < 2; k++) begin
      g = k ? (4'($random(seed)) | 4'h1) : 4'h0;
      clr;
      bus(1'b1, 8'h00, {20'h0, g, 8'h0c});
      gpio_in <= ~g;
      tick(6);
      cb(low_power_state_one, 1'b1);
      cb(usb_pll_enable, 1'b0);
      bus(1'b0, 8'h00, 32'h0);
      cb(q[3], 1'b0);
      if (k == 1) gpio_in <= g;
      else eth_link_up <= 1'b1;
      n = 0;
      while (low_power_state_one !== 1'b0 && n < 100) begin
        tick(1);
        n++;
      end
      tick(2);
      wait_ready;
      cb(seen_mac, 1'b1);
      cb(seen_full, 1'b0);
      cb(usb_pll_enable, 1'b1);
      bus(1'b0, 8'h00, 32'h0);
      cb(q[3], 1'b1);
      eth_link_up <= 1'b0;
      gpio_in <= 4'h0;
    end
    // lite reset leaves the sequencer in run; host pipe resync has no port here
    clr;
    bus(1'b1, 8'h00, 32'h2);
    cb(core_reset, 1'b1);
    cb(usb_core_reset, 1'b0);
    tick(30);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h20);
    cb(core_reset, 1'b0);
    cb(seen_full | seen_det, 1'b0);
    cb(usb_pll_enable, 1'b1);
    clr;
    usb_bus_reset <= 1'b1;
    tick(1);
    usb_bus_reset <= 1'b0;
    tick(4);
    wait_ready;
    cb(seen_mac, 1'b1);
    cb(seen_full | seen_det, 1'b0);
    // strap levels are driven on strap_in by the bench
    s = 4'($random(seed));
    strap_in <= s;
    external_reset_n <= 1'b0;
    tick(3);
    cb(chip_reset, 1'b1);
    cb(usb_core_reset, 1'b1);
    cb(phy_power_down, 1'b1);
    chk({28'h0, strap_oe}, 32'h0);
    bus(1'b0, 8'h04, 32'h0);
    cb(q[0], 1'b0);
    external_reset_n <= 1'b1;
    tick(2);
    wait_ready;
    strap_in <= ~s;
    tick(2);
    chk({28'h0, strap_value}, {28'h0, s});
    chk({28'h0, strap_oe}, 32'hf);
    clr;
    usb_power_detect <= 1'b0;
    tick(3);
    external_reset_n <= 1'b0;
    tick(3);
    bus(1'b0, 8'h08, 32'h0);
    chk(q, 32'h02);
    external_reset_n <= 1'b1;
    tick(2);
    usb_power_detect <= 1'b1;
    tick(2);
    wait_ready;
    cb(seen_full, 1'b1);
    bus(1'b1, 8'hfc, 32'hffff_ffff);
    bus(1'b0, 8'hfc, 32'h0);
    chk(q, 32'h0);
    results();
  end
endmodule : test_reset_and_usb_detach_control
